// [rtl/sgcf_params.svh]
// Constants of the serial gate control and fault port
// Assumes a 50 MHz system clock and microsecond fault timebase
`ifndef SGCF_PARAMS_SVH
`define SGCF_PARAMS_SVH

// Clock and timebase
`define SGCF_CLK_NS 20
`define SGCF_TICK_NS 1000
`define SGCF_TICK_CYC (`SGCF_TICK_NS / `SGCF_CLK_NS)
`define SGCF_US_PER_MS 1000

// Frame layout: gate bits, deglitch select bits, sleep bit
`define SGCF_GATE_MSB 7
`define SGCF_GATE_LSB 4
`define SGCF_SEL_MSB 3
`define SGCF_SEL_LSB 1
`define SGCF_SLEEP_BIT 0
`define SGCF_FRAME_BITS 8

// Reset values
`define SGCF_SEL_RST 3'h0
`define SGCF_CTRL_RST 4'h0

// Fault codes, high bit then low bit
`define SGCF_CODE_OV 2'h0
`define SGCF_CODE_OL 2'h1
`define SGCF_CODE_OC 2'h2
`define SGCF_CODE_STG 2'h3

// Deglitch and retry times, indexed by the low two select bits
`define SGCF_STG_US_0 16
`define SGCF_STG_US_1 4
`define SGCF_STG_US_2 8
`define SGCF_STG_US_3 32
`define SGCF_STGL_US_0 120
`define SGCF_STGL_US_1 30
`define SGCF_STGL_US_2 60
`define SGCF_STGL_US_3 240
`define SGCF_OCOL_US_0 120
`define SGCF_OCOL_US_1 30
`define SGCF_OCOL_US_2 60
`define SGCF_OCOL_US_3 240
`define SGCF_RETRY_MS_0 16
`define SGCF_RETRY_MS_1 4
`define SGCF_RETRY_MS_2 8
`define SGCF_RETRY_MS_3 32

`endif

// [rtl/sgcf_pkg.sv]
// Types shared by the serial gate control and fault port
// Assumes the constants header is compiled alongside
`default_nettype none
package sgcf_pkg;
    // Serial pins as sampled
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } sgcf_pins_t;

    // Fault timer limits in microseconds
    typedef struct packed {
        logic [15:0] stg;
        logic [15:0] oc;
        logic [15:0] ol;
        logic [15:0] retry;
    } sgcf_limits_t;

    // Per-channel detector levels
    typedef struct packed {
        logic stg;
        logic oc;
        logic ol;
    } sgcf_det_t;
endpackage : sgcf_pkg
`default_nettype wire

// [rtl/sgcf_chan_timer.sv]
// One channel of deglitch filters and auto-retry timer
// Assumes synchronised detector levels and a one-cycle microsecond tick
`default_nettype none
module sgcf_chan_timer
    import sgcf_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic tick, // One pulse per microsecond
    input wire logic restart, // Select changed, reload counters
    input wire sgcf_limits_t lim, // Selected durations
    input wire sgcf_det_t det, // Detector levels
    input wire logic on_cmd, // Channel commanded on
    input wire logic retry_mode, // Low selects auto-retry
    output sgcf_det_t evt, // Deglitched fault pulses
    output logic block // Gate held off by fault
);
    // All state of the channel
    typedef struct packed {
        logic [15:0] stg_cnt; // Short-to-ground filter
        logic [15:0] oc_cnt; // Over-current filter
        logic [15:0] ol_cnt; // Open-load filter
        logic [15:0] retry_cnt; // Auto-retry wait
        sgcf_det_t evt; // Event pulses
        logic block; // Gate held off
    } sgcf_tmr_t;

    sgcf_tmr_t st; // Current state
    sgcf_tmr_t next_st; // Next state

    // Filters count only while their condition holds unbroken
    always_comb begin
        next_st = st;
        next_st.evt = '0;
        if (restart) begin // Reload on new durations
            next_st.stg_cnt = '0;
            next_st.oc_cnt = '0;
            next_st.ol_cnt = '0;
            next_st.retry_cnt = '0;
        end else if (tick) begin
            // On-state faults filtered only while driving
            next_st.stg_cnt = (det.stg && on_cmd && !st.block) ? st.stg_cnt + 16'h1 : '0;
            next_st.oc_cnt = (det.oc && on_cmd && !st.block) ? st.oc_cnt + 16'h1 : '0;
            // Open load is an off-state check
            next_st.ol_cnt = (det.ol && !on_cmd) ? st.ol_cnt + 16'h1 : '0;
            next_st.retry_cnt = st.block ? st.retry_cnt + 16'h1 : '0;
            if (next_st.stg_cnt >= lim.stg && det.stg && on_cmd && !st.block) begin
                next_st.evt.stg = 1'b1;
                next_st.block = 1'b1;
                next_st.stg_cnt = '0;
            end else if (next_st.oc_cnt >= lim.oc && det.oc && on_cmd && !st.block) begin
                next_st.evt.oc = 1'b1;
                next_st.block = 1'b1;
                next_st.oc_cnt = '0;
            end
            if (next_st.ol_cnt >= lim.ol && det.ol && !on_cmd) begin
                next_st.evt.ol = 1'b1;
                next_st.ol_cnt = '0;
            end
            // Timer expiry re-enables only in auto-retry mode
            if (st.block && !retry_mode && next_st.retry_cnt >= lim.retry) begin
                next_st.block = 1'b0;
                next_st.retry_cnt = '0;
            end
        end
        // Dropping the command always re-arms; user may beat the retry duty
        if (!on_cmd) begin
            next_st.block = 1'b0;
            next_st.retry_cnt = '0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt = st.evt;
    assign block = st.block;
endmodule // sgcf_chan_timer
`default_nettype wire

// [rtl/sgcf_port.sv]
// Serial control and fault reporting port of a four-channel gate driver
// Assumes serial pins from a slower host; all pins are asynchronous
`default_nettype none
`include "sgcf_params.svh"
module sgcf_port
    import sgcf_pkg::*;
#(
    parameter int CHANNELS = 4 // Gate channels
) (
    input wire logic clk, // System clock, 50 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic cs_n, // Chip select pin, active low
    input wire logic sclk, // Serial clock pin
    input wire logic sdi, // Serial data in pin
    input wire logic [3:0] parallel_channel_inputs, // Direct gate commands
    input wire logic retry_mode_select, // Low selects auto-retry
    input wire logic supply_overvoltage, // Supply lockout detector
    input wire logic [3:0] short_ground_det, // Short-to-ground comparators
    input wire logic [3:0] overcurrent_det, // Over-current comparators
    input wire logic [3:0] open_load_det, // Open-load comparators
    output logic sdo, // Serial data out level
    output logic sdo_oe, // Serial data out enable
    output logic fault_interrupt_n_o, // Interrupt pin level, always low
    output logic fault_interrupt_n_oe, // Interrupt pin pulls low
    output logic [3:0] gate_drive_outputs, // Gate enables
    output logic [2:0] deglitch_sel, // Current deglitch select
    output logic sleep_state // Low-current sleep request
);
    // All state of the port except the reset release chain
    typedef struct packed {
        sgcf_pins_t pin_s1; // Pin sync, first stage
        sgcf_pins_t pin_s2; // Pin sync, second stage
        sgcf_pins_t pin_q; // Previous sample for edges
        logic [3:0] par_s1; // Parallel sync
        logic [3:0] par_s2;
        logic ar_s1; // Retry mode sync
        logic ar_s2;
        logic ov_s1; // Over-voltage sync
        logic ov_s2;
        logic [11:0] det_s1; // Detector sync
        logic [11:0] det_s2;
        logic [7:0] shift; // Shift and fault register
        logic [3:0] ctrl; // Output control buffer
        logic [2:0] sel; // Deglitch select
        logic sleep; // Sleep latch
        logic seen; // Clock rise seen this frame
        logic sdo; // Serial out level
        logic sdo_oe; // Serial out enable
        logic int_low; // Interrupt latched
        logic [3:0] gate; // Gate outputs
        logic [5:0] tick_cnt; // Microsecond divider
        logic tick; // Microsecond pulse
        logic restart; // Select changed
    } sgcf_st_t;

    localparam logic [5:0] TICK_LAST = 6'(`SGCF_TICK_CYC - 1); // Divider wrap

    logic [1:0] rst_sync; // Reset release chain
    logic rst_n; // Synchronised reset
    sgcf_st_t st; // Current state
    sgcf_st_t next_st; // Next state
    sgcf_det_t evt [CHANNELS]; // Deglitched events
    logic [CHANNELS-1:0] blk; // Channels held off
    sgcf_limits_t lim; // Selected durations
    logic cs_fall; // Select falling edge
    logic cs_rise; // Select rising edge
    logic sclk_rise; // Clock rising edge
    logic sclk_fall; // Clock falling edge
    logic [3:0] on_cmd; // Commanded gate state
    logic any_evt; // Any new fault event
    logic any_active; // Any channel held off, or lockout present

    // Reset released through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Edges from the settled samples only
    assign cs_fall = st.pin_q.cs_n && !st.pin_s2.cs_n;
    assign cs_rise = !st.pin_q.cs_n && st.pin_s2.cs_n;
    assign sclk_rise = !st.pin_s2.cs_n && !st.pin_q.sclk && st.pin_s2.sclk;
    assign sclk_fall = !st.pin_s2.cs_n && st.pin_q.sclk && !st.pin_s2.sclk;
    assign on_cmd = st.ctrl | st.par_s2;

    // Duration lookup from the select register
    always_comb begin
        lim = '0;
        case (st.sel[1:0])
            2'h0: begin
                lim.stg = st.sel[2] ? 16'(`SGCF_STGL_US_0) : 16'(`SGCF_STG_US_0);
                lim.oc = 16'(`SGCF_OCOL_US_0);
                lim.retry = 16'(`SGCF_RETRY_MS_0 * `SGCF_US_PER_MS);
            end
            2'h1: begin
                lim.stg = st.sel[2] ? 16'(`SGCF_STGL_US_1) : 16'(`SGCF_STG_US_1);
                lim.oc = 16'(`SGCF_OCOL_US_1);
                lim.retry = 16'(`SGCF_RETRY_MS_1 * `SGCF_US_PER_MS);
            end
            2'h2: begin
                lim.stg = st.sel[2] ? 16'(`SGCF_STGL_US_2) : 16'(`SGCF_STG_US_2);
                lim.oc = 16'(`SGCF_OCOL_US_2);
                lim.retry = 16'(`SGCF_RETRY_MS_2 * `SGCF_US_PER_MS);
            end
            default: begin
                lim.stg = st.sel[2] ? 16'(`SGCF_STGL_US_3) : 16'(`SGCF_STG_US_3);
                lim.oc = 16'(`SGCF_OCOL_US_3);
                lim.retry = 16'(`SGCF_RETRY_MS_3 * `SGCF_US_PER_MS);
            end
        endcase
        lim.ol = lim.oc;
    end

    // Per-channel filters and retry timers
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            sgcf_chan_timer u_tmr (
                .clk(clk),
                .rst_n(rst_n),
                .tick(st.tick),
                .restart(st.restart),
                .lim(lim),
                .det({st.det_s2[8 + gi], st.det_s2[4 + gi], st.det_s2[gi]}),
                .on_cmd(on_cmd[gi]),
                .retry_mode(st.ar_s2),
                .evt(evt[gi]),
                .block(blk[gi])
            );
        end
    endgenerate

    // Summary of fault activity
    always_comb begin
        // Lockout flags the interrupt with no channel code
        any_evt = st.ov_s2;
        any_active = st.ov_s2;
        for (int i = 0; i < CHANNELS; i++) begin
            any_evt = any_evt | (|evt[i]);
            any_active = any_active | blk[i];
        end
    end

    // Port sequencing, fault capture and gate drive
    always_comb begin
        next_st = st;
        next_st.pin_s1 = '{cs_n: cs_n, sclk: sclk, sdi: sdi};
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_q = st.pin_s2;
        next_st.par_s1 = parallel_channel_inputs;
        next_st.par_s2 = st.par_s1;
        next_st.ar_s1 = retry_mode_select;
        next_st.ar_s2 = st.ar_s1;
        next_st.ov_s1 = supply_overvoltage;
        next_st.ov_s2 = st.ov_s1;
        next_st.det_s1 = {short_ground_det, overcurrent_det, open_load_det};
        next_st.det_s2 = st.det_s1;
        next_st.restart = 1'b0;
        // Microsecond timebase
        next_st.tick = (st.tick_cnt == TICK_LAST);
        next_st.tick_cnt = next_st.tick ? 6'h0 : st.tick_cnt + 6'h1;
        if (cs_fall) begin
            next_st.seen = 1'b0;
            next_st.sdo = st.shift[7];
            next_st.sdo_oe = 1'b1;
        end else if (sclk_rise) begin
            next_st.shift = {st.shift[6:0], st.pin_s2.sdi};
            next_st.seen = 1'b1;
        end else if (sclk_fall && st.seen) begin
            next_st.sdo = st.shift[7];
        end
        if (cs_rise) begin
            next_st.sdo_oe = 1'b0;
            next_st.shift = '0;
            if (st.seen) begin
                // First bit in lands on top and belongs to channel zero
                for (int i = 0; i < CHANNELS; i++) begin
                    next_st.ctrl[i] = st.shift[`SGCF_GATE_MSB - i];
                end
                next_st.sel = st.shift[`SGCF_SEL_MSB:`SGCF_SEL_LSB];
                next_st.sleep = st.shift[`SGCF_SLEEP_BIT];
                next_st.restart = (st.shift[`SGCF_SEL_MSB:`SGCF_SEL_LSB] != st.sel);
            end
        end
        // Idle register collects fault codes, set winning over re-arm
        if (st.pin_s2.cs_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (evt[i].stg) begin
                    next_st.shift[7 - 2 * i -: 2] = `SGCF_CODE_STG;
                end else if (evt[i].oc) begin
                    next_st.shift[7 - 2 * i -: 2] = `SGCF_CODE_OC;
                end else if (evt[i].ol) begin
                    next_st.shift[7 - 2 * i -: 2] = `SGCF_CODE_OL;
                end
            end
        end
        // Interrupt latch: refresh on select fall, new events always win
        next_st.int_low = (cs_fall ? any_active : st.int_low) | any_evt;
        // Lockout forces every gate off
        next_st.gate = st.ov_s2 ? 4'h0 : (on_cmd & ~blk);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{pin_s1: '{cs_n: 1'b1, default: 1'b0}, pin_s2: '{cs_n: 1'b1, default: 1'b0},
                    pin_q: '{cs_n: 1'b1, default: 1'b0}, ctrl: `SGCF_CTRL_RST,
                    sel: `SGCF_SEL_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign sdo = st.sdo;
    assign sdo_oe = st.sdo_oe;
    assign fault_interrupt_n_o = 1'b0;
    assign fault_interrupt_n_oe = st.int_low;
    assign gate_drive_outputs = st.gate;
    assign deglitch_sel = st.sel;
    assign sleep_state = st.sleep;

    // Output goes high impedance after select rises
    sdo_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
        cs_rise |=> !sdo_oe)
        else $error("serial out still enabled after select rise");

    // Fault MSB presented one cycle after select falls
    sdo_msb_a: assert property (@(posedge clk) disable iff (!rst_n)
        cs_fall |=> sdo_oe && sdo == $past(st.shift[7]))
        else $error("fault MSB not presented at select fall");

    // No second bit before a clock rise
    sdo_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sdo_oe && !st.seen && !cs_fall && !st.pin_s2.cs_n) |=> $stable(sdo))
        else $error("serial out advanced before first clock rise");

    // Shift takes input data on a clock rise
    shift_in_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sclk_rise && !cs_rise && !cs_fall) |=>
            st.shift == {$past(st.shift[6:0]), $past(st.pin_s2.sdi)})
        else $error("shift register did not take input bit");

    // Control latched from the frame at select rise
    ctrl_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cs_rise && st.seen) |=> deglitch_sel == $past(st.shift[3:1])
            && st.ctrl == {$past(st.shift[4]), $past(st.shift[5]), $past(st.shift[6]),
            $past(st.shift[7])} && sleep_state == $past(st.shift[0]))
        else $error("control or sleep not latched at select rise");

    // Clockless frame leaves control untouched
    ctrl_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cs_rise && !st.seen) |=> $stable(st.ctrl) && $stable(deglitch_sel))
        else $error("control changed without a clock");

    // Select register starts at zero
    sel_reset_a: assert property (@(posedge clk)
        $rose(rst_n) |-> deglitch_sel == 3'h0)
        else $error("deglitch select not zero after reset");

    // Interrupt held until select falls
    int_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (fault_interrupt_n_oe && !cs_fall) |=> fault_interrupt_n_oe)
        else $error("interrupt released without select fall");

    // Parallel input drives the gate with no serial activity
    par_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.par_s2[0] && !blk[0] && !st.ov_s2) |=> gate_drive_outputs[0])
        else $error("parallel input did not drive gate");

    // Short-to-ground event recorded as code three
    stg_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        (evt[0].stg && st.pin_s2.cs_n) |=> st.shift[7:6] == 2'h3)
        else $error("short-to-ground code not captured");
endmodule // sgcf_port
`default_nettype wire

// [verification/sgcf_host.sv]
// Host model driving chip select, serial clock and serial data in
// Assumes the bench clock paces it and the line level of serial out is fed in
`default_nettype none
module sgcf_host (
    input wire logic clk, // Bench clock used for pacing
    input wire logic sdo_wire, // Serial out as seen on the line
    output logic cs_n, // Chip select, active low
    output logic sclk, // Serial clock, still between frames
    output logic sdi // Serial data in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels: select high, clock and data low like their pull-downs
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // Wait whole clocks, then step off the edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One frame of nbits, MSB first; serial out sampled before each rise
    task automatic frame(input int nbits, input logic [15:0] data, output logic [15:0] rx);
        rx = 16'h0;
        cs_n = 1'b0;
        wait_clk(10);
        for (int i = 0; i < nbits; i++) begin
            sdi = data[nbits - 1 - i];
            wait_clk(4);
            rx = {rx[14:0], sdo_wire};
            sclk = 1'b1;
            wait_clk(4);
            sclk = 1'b0;
        end
        wait_clk(10);
        cs_n = 1'b1;
        sdi = 1'b0;
        wait_clk(10);
    endtask

    // Select pulse with no clock edge in it
    task automatic pulse();
        cs_n = 1'b0;
        wait_clk(10);
        cs_n = 1'b1;
        wait_clk(10);
    endtask
endmodule // sgcf_host
`default_nettype wire

// [verification/tb_serial_gate_control_fault_port.sv]
// Self-checking bench for the serial gate control and fault port
// Assumes the host model drives the link; detectors are driven here
`default_nettype none
module tb_serial_gate_control_fault_port;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_b, cs_n, sclk, sdi, retry_mode_select, supply_overvoltage; // Drives
    logic [3:0] parallel_channel_inputs, short_ground_det, overcurrent_det, open_load_det;
    logic sdo, sdo_oe, fault_interrupt_n_o, fault_interrupt_n_oe, sleep_state; // Results
    logic [3:0] gate_drive_outputs;
    logic [2:0] deglitch_sel;
    logic [15:0] rx; // Bits read back by the host
    int num_errors = 0;
    int cmp_count = 0;
    // Released serial out shows the inverse; the interrupt line has a pull-up
    wire sdo_wire = sdo_oe ? sdo : ~sdo;
    wire fault_n = fault_interrupt_n_oe ? fault_interrupt_n_o : 1'b1;

    sgcf_port i_dut (.clk(clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .parallel_channel_inputs(parallel_channel_inputs),
        .retry_mode_select(retry_mode_select), .supply_overvoltage(supply_overvoltage),
        .short_ground_det(short_ground_det), .overcurrent_det(overcurrent_det),
        .open_load_det(open_load_det), .sdo(sdo), .sdo_oe(sdo_oe),
        .fault_interrupt_n_o(fault_interrupt_n_o), .fault_interrupt_n_oe(fault_interrupt_n_oe),
        .gate_drive_outputs(gate_drive_outputs), .deglitch_sel(deglitch_sel),
        .sleep_state(sleep_state));
    sgcf_host i_host (.clk(clk), .sdo_wire(sdo_wire), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare a vector result
    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare the control outputs against a latched byte
    task automatic check_ctl(input logic [7:0] b);
        check_vec(16'(gate_drive_outputs), 16'({b[4], b[5], b[6], b[7]}));
        check_vec(16'(deglitch_sel), 16'(b[3:1]));
        check_vec(16'(sleep_state), 16'(b[0]));
    endtask

    // Reset values
    task automatic test_reset();
        check_vec(16'(deglitch_sel), 16'h0);
        check_vec(16'({gate_drive_outputs, sleep_state, sdo_oe}), 16'h0);
        check_vec(16'(fault_n), 16'h1);
        $display("test reset done");
    endtask

    // Plain frames: control applied, no fault read, output released
    task automatic test_frame();
        i_host.frame(8, 16'h00a5, rx);
        check_vec(rx, 16'h0000);
        check_ctl(8'ha5);
        check_vec(16'(sdo_oe), 16'h0);
        i_host.frame(8, 16'h0000, rx);
        check_ctl(8'h00);
        $display("test frame done");
    endtask

    // Sixteen bits: fault byte, then the first byte, last byte is control
    task automatic test_cascade();
        i_host.frame(16, 16'h3cf2, rx);
        check_vec(rx, 16'h003c);
        check_ctl(8'hf2);
        i_host.pulse();
        check_ctl(8'hf2);
        $display("test cascade done");
    endtask

    // Four bits leave fault data in the upper half
    task automatic test_short();
        i_host.frame(4, 16'h000f, rx);
        check_ctl(8'h0f);
        $display("test short done");
    endtask

    // Parallel inputs drive the gates with the serial gate bits clear
    task automatic test_parallel();
        i_host.frame(8, 16'h0002, rx);
        parallel_channel_inputs = 4'h5;
        i_host.wait_clk(10);
        check_vec(16'(gate_drive_outputs), 16'h0005);
        parallel_channel_inputs = 4'h0;
        i_host.wait_clk(10);
        check_vec(16'(gate_drive_outputs), 16'h0000);
        $display("test parallel done");
    endtask

    // Short, over-current and open-load on three channels, latched mode
    task automatic test_faults();
        retry_mode_select = 1'b1;
        i_host.frame(8, 16'h0062, rx);
        short_ground_det = 4'h2;
        overcurrent_det = 4'h4;
        open_load_det = 4'h8;
        i_host.wait_clk(2500);
        check_vec(16'(fault_n), 16'h0);
        check_vec(16'(gate_drive_outputs), 16'h0000);
        short_ground_det = 4'h0;
        overcurrent_det = 4'h0;
        open_load_det = 4'h0;
        i_host.wait_clk(10);
        check_vec(16'(fault_n), 16'h0);
        i_host.frame(8, 16'h0002, rx);
        check_vec(rx, 16'h0039);
        i_host.frame(8, 16'h0002, rx);
        check_vec(rx, 16'h0000);
        check_vec(16'(fault_n), 16'h1);
        $display("test faults done");
    endtask

    // Over-voltage forces gates off and flags without a code
    task automatic test_overvoltage();
        i_host.frame(8, 16'h00f0, rx);
        supply_overvoltage = 1'b1;
        i_host.wait_clk(20);
        check_vec(16'({gate_drive_outputs, fault_n}), 16'h0000);
        supply_overvoltage = 1'b0;
        i_host.wait_clk(20);
        check_vec(16'(gate_drive_outputs), 16'h000f);
        i_host.frame(8, 16'h0000, rx);
        check_vec(rx, 16'h0000);
        check_vec(16'(fault_n), 16'h1);
        $display("test overvoltage done");
    endtask

    // Auto-retry mode: faults hold gates off while the long retry timer runs
    task automatic test_retry();
        retry_mode_select = 1'b0;
        i_host.frame(8, 16'h0092, rx);
        check_vec(16'(gate_drive_outputs), 16'h0009);
        short_ground_det = 4'h1;
        overcurrent_det = 4'h8;
        open_load_det = 4'h2;
        i_host.wait_clk(2500);
        check_vec(16'({gate_drive_outputs, fault_n}), 16'h0000);
        short_ground_det = 4'h0;
        overcurrent_det = 4'h0;
        open_load_det = 4'h0;
        i_host.wait_clk(10);
        check_vec(16'(gate_drive_outputs), 16'h0000);
        i_host.frame(8, 16'h0002, rx);
        check_vec(rx, 16'h00d2);
        $display("test retry done");
    endtask

    // Counts and verdict, then the end of the run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        retry_mode_select = 1'b0;
        supply_overvoltage = 1'b0;
        parallel_channel_inputs = 4'h0;
        short_ground_det = 4'h0;
        overcurrent_det = 4'h0;
        open_load_det = 4'h0;
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        i_host.wait_clk(10);
        test_reset();
        test_frame();
        test_cascade();
        test_short();
        test_parallel();
        test_faults();
        test_overvoltage();
        test_retry();
        report_and_stop();
    end

    // Watchdog well beyond the expected run of some 6300 clocks
    initial begin
        #1ms;
        num_errors++;
        report_and_stop();
    end
endmodule // tb_serial_gate_control_fault_port
`default_nettype wire
